// *** rtl/fic_chain.sv ***
// Turbo interleaver address generator, bit-wise interleaver with puncturing,
// unit FIFO and 48-branch convolutional time interleaver.
// Assumes one clock, encoder and frame assembler on that clock.
`timescale 1ns/100ps
module fic_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fic_fifo depth must be a power of two");
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  logic             full;
  logic             empty;
  assign full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty     = wp_q == rp_q;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp_q[AW-1:0]];
  always_ff @(posedge clk_sys)
  begin
    if (in_valid && !full)
    begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (in_valid && !full)
      begin
        wp_q <= wp_q + 1'b1;
      end
      if (out_ready && !empty)
      begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule

module fic_chain #(
  parameter int MAX_CODED = 61440,
  parameter int MAX_DEPTH = 8,
  parameter int DEPTH_W   = 4,
  parameter int FIFO_D    = 16
) (
  input  wire logic                                 clk_sys,
  input  wire logic                                 arst_n,
  input  wire logic                                 tb_start,
  input  wire logic [13:0]                          tb_len,
  output logic [13:0]                               tb_addr,
  output logic                                      tb_addr_valid,
  output logic                                      tb_done,
  output logic                                      tb_busy,
  input  wire logic                                 in_bit,
  input  wire logic                                 in_sow,
  input  wire logic                                 in_valid,
  output logic                                      in_ready,
  input  wire logic [2:0]                           rate_sel,
  input  wire logic                                 sig_word,
  input  wire logic [`FIC_BRANCHES-1:0][DEPTH_W-1:0] tap_depth,
  output fic_pkg::fic_unit_t                        out_unit,
  output logic                                      out_valid,
  input  wire logic                                 out_ready
);
  if (MAX_CODED < 61440 || MAX_CODED > 65535) $error("fic_chain MAX_CODED out of range");
  if (MAX_DEPTH < 1 || (1 << DEPTH_W) <= MAX_DEPTH) $error("fic_chain DEPTH_W too small");

  localparam logic [5:0] LUT6 [32] = '{6'h03, 6'h1B, 6'h0F, 6'h0D, 6'h1D, 6'h05, 6'h01,
    6'h1F, 6'h03, 6'h09, 6'h0F, 6'h1F, 6'h11, 6'h05, 6'h27, 6'h01, 6'h13, 6'h1B, 6'h0F,
    6'h0D, 6'h2D, 6'h05, 6'h21, 6'h0F, 6'h0D, 6'h09, 6'h0F, 6'h1F, 6'h11, 6'h05, 6'h0F, 6'h21};
  localparam logic [8:0] LUT9 [32] = '{9'h00D, 9'h14F, 9'h057, 9'h00F, 9'h00F, 9'h001,
    9'h14D, 9'h00B, 9'h00D, 9'h001, 9'h079, 9'h09B, 9'h001, 9'h0AF, 9'h1A5, 9'h005, 9'h1FD,
    9'h0D7, 9'h02F, 9'h1A9, 9'h127, 9'h0E5, 9'h1AB, 9'h053, 9'h199, 9'h183, 9'h0C1, 9'h039,
    9'h1F5, 9'h139, 9'h1E9, 9'h187};
  localparam logic [16:0] CLEN [8] = '{17'h0F000, 17'h0D800, 17'h0C000, 17'h0A800,
    17'h09000, 17'h07800, 17'h06000, 17'h04800};
  localparam logic [7:0] CMUL [8] = '{8'hF7, 8'hF5, 8'hDD, 8'hC5, 8'hB9, 8'hA7, 8'h9D, 8'h7D};

  function automatic logic [3:0] fic_pick_n(input logic [13:0] len);
    logic [3:0] n;
    n = 4'h9;
    for (int k = 9; k >= 0; k--)
    begin
      if ({1'b0, len} <= (15'h0001 << (k + 5)))
      begin
        n = 4'(k);
      end
    end
    return n;
  endfunction

  function automatic logic [4:0] fic_rev5(input logic [4:0] v);
    logic [4:0] r;
    r = '0;
    for (int k = 0; k < 5; k++)
    begin
      r[k] = v[4-k];
    end
    return r;
  endfunction

  function automatic logic [DEPTH_W-1:0] fic_clamp(input logic [DEPTH_W-1:0] d);
    return (int'(d) > MAX_DEPTH) ? DEPTH_W'(MAX_DEPTH) : d;
  endfunction

  // Turbo interleaver address generator
  logic [13:0] tb_len_q;
  logic [3:0]  tb_n_q;
  logic [13:0] tb_cnt_q;
  logic [13:0] tb_emit_q;
  logic [13:0] tb_mask;
  logic [13:0] tb_inc;
  logic [8:0]  tb_lut;
  logic [22:0] tb_prod;
  logic [13:0] tb_cand;
  logic        tb_hit;
  assign tb_mask = (14'h0001 << tb_n_q) - 14'h0001;
  assign tb_inc  = ((tb_cnt_q >> 5) + 14'h0001) & tb_mask;
  assign tb_lut  = (tb_n_q == 4'h9) ? LUT9[tb_cnt_q[4:0]] : {3'h0, LUT6[tb_cnt_q[4:0]]};
  assign tb_prod = tb_inc * tb_lut;
  assign tb_cand = ({9'h000, fic_rev5(tb_cnt_q[4:0])} << tb_n_q)
                 | (tb_prod[13:0] & tb_mask);
  assign tb_hit  = tb_busy && (tb_cand < tb_len_q);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tb_len_q      <= '0;
      tb_n_q        <= 4'h0;
      tb_cnt_q      <= `FIC_ADDR_RST;
      tb_emit_q     <= '0;
      tb_busy       <= 1'b0;
      tb_done       <= 1'b0;
      tb_addr       <= `FIC_ADDR_RST;
      tb_addr_valid <= 1'b0;
    end
    else
    begin
      tb_done       <= 1'b0;
      tb_addr_valid <= 1'b0;
      if (tb_start && !tb_busy && tb_len != 14'h0000)
      begin
        tb_len_q  <= tb_len;
        tb_n_q    <= fic_pick_n(tb_len);
        tb_cnt_q  <= `FIC_ADDR_RST;
        tb_emit_q <= '0;
        tb_busy   <= 1'b1;
      end
      else if (tb_busy)
      begin
        tb_cnt_q <= tb_cnt_q + 14'h0001;
        if (tb_hit)
        begin
          tb_addr       <= tb_cand;
          tb_addr_valid <= 1'b1;
          tb_emit_q     <= tb_emit_q + 14'h0001;
          if (tb_emit_q + 14'h0001 == tb_len_q)
          begin
            tb_busy <= 1'b0;
            tb_done <= 1'b1;
          end
        end
      end
    end
  end

  // Bit-wise interleaver: fill a word, then read it in permuted order
  fic_pkg::fic_state_t st_q;
  logic              bmem [MAX_CODED];
  logic [15:0]       wcnt_q;
  logic [16:0]       clen_q;
  logic [7:0]        mul_q;
  logic              sig_q;
  logic [16:0]       h_q;
  logic [15:0]       rcnt_q;
  logic [6:0]        g_q;
  logic [`FIC_UNIT_BITS-1:0] pk_data_q;
  logic [6:0]        pk_cnt_q;
  logic              pk_vld_q;
  logic              pk_sow_q;
  logic              pk_sig_q;
  logic              pk_first_q;
  logic              pk_ready;
  logic              rd_step;
  logic              rd_keep;
  logic              rd_last;
  logic [16:0]       h_sum;
  assign in_ready = st_q != fic_pkg::FIC_ST_READ;
  assign rd_step  = (st_q == fic_pkg::FIC_ST_READ) && !pk_vld_q;
  assign rd_keep  = sig_q || (g_q < 7'(`FIC_UNIT_BITS));
  assign rd_last  = {1'b0, rcnt_q} == clen_q - 17'h00001;
  assign h_sum    = h_q + {9'h000, mul_q};

  always_ff @(posedge clk_sys)
  begin
    if (in_valid && in_ready && (in_sow || st_q == fic_pkg::FIC_ST_FILL))
    begin
      bmem[in_sow ? 16'h0000 : wcnt_q] <= in_bit;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q   <= fic_pkg::FIC_ST_IDLE;
      wcnt_q <= '0;
      clen_q <= `FIC_SIG_LEN;
      mul_q  <= `FIC_SIG_MULT;
      sig_q  <= 1'b1;
    end
    else
    begin
      case (st_q)
        fic_pkg::FIC_ST_IDLE,
        fic_pkg::FIC_ST_FILL:
        begin
          if (in_valid && in_sow)
          begin
            clen_q <= sig_word ? `FIC_SIG_LEN : CLEN[rate_sel];
            mul_q  <= sig_word ? `FIC_SIG_MULT : CMUL[rate_sel];
            sig_q  <= sig_word;
            wcnt_q <= 16'h0001;
            st_q   <= fic_pkg::FIC_ST_FILL;
          end
          else if (in_valid && st_q == fic_pkg::FIC_ST_FILL)
          begin
            wcnt_q <= wcnt_q + 16'h0001;
            if ({1'b0, wcnt_q} == clen_q - 17'h00001)
            begin
              st_q <= fic_pkg::FIC_ST_READ;
            end
          end
        end
        fic_pkg::FIC_ST_READ:
        begin
          if (rd_step && rd_last)
          begin
            st_q <= fic_pkg::FIC_ST_IDLE;
          end
        end
        default:
        begin
          st_q <= fic_pkg::FIC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      h_q    <= '0;
      rcnt_q <= '0;
      g_q    <= '0;
    end
    else if (st_q != fic_pkg::FIC_ST_READ)
    begin
      h_q    <= '0;
      rcnt_q <= '0;
      g_q    <= '0;
    end
    else if (rd_step)
    begin
      h_q    <= (h_sum >= clen_q) ? h_sum - clen_q : h_sum;
      rcnt_q <= rcnt_q + 16'h0001;
      g_q    <= g_q + 7'h01;
    end
  end

  // Packing of kept bits into interleaving units
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pk_data_q  <= '0;
      pk_cnt_q   <= '0;
      pk_vld_q   <= 1'b0;
      pk_sow_q   <= 1'b0;
      pk_sig_q   <= 1'b0;
      pk_first_q <= 1'b0;
    end
    else
    begin
      if (st_q == fic_pkg::FIC_ST_FILL)
      begin
        pk_first_q <= 1'b1;
      end
      if (pk_vld_q && pk_ready)
      begin
        pk_vld_q  <= 1'b0;
        pk_data_q <= '0;
      end
      else if (rd_step)
      begin
        if (rd_keep)
        begin
          pk_data_q[pk_cnt_q] <= bmem[h_q[15:0]];
        end
        if ((rd_keep && pk_cnt_q == 7'(`FIC_UNIT_BITS - 1))
            || (rd_last && (rd_keep || pk_cnt_q != 7'h00)))
        begin
          pk_cnt_q   <= '0;
          pk_vld_q   <= 1'b1;
          pk_sow_q   <= pk_first_q;
          // Kept with the unit: a new word may retag sig_q while this one waits
          pk_sig_q   <= sig_q;
          pk_first_q <= 1'b0;
        end
        else if (rd_keep)
        begin
          pk_cnt_q <= pk_cnt_q + 7'h01;
        end
      end
    end
  end

  fic_pkg::fic_unit_t pk_unit;
  fic_pkg::fic_unit_t fq_unit;
  logic               fq_vld;
  logic               take;
  assign pk_unit = '{sow: pk_sow_q, sig: pk_sig_q, cu_last: 1'b0, data: pk_data_q};

  fic_fifo #(
    .WIDTH ($bits(fic_pkg::fic_unit_t)),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .in_data   (pk_unit),
    .in_valid  (pk_vld_q),
    .in_ready  (pk_ready),
    .out_data  (fq_unit),
    .out_valid (fq_vld),
    .out_ready (take)
  );

  // Convolutional time interleaver
  logic [`FIC_UNIT_BITS-1:0] tmem [`FIC_BRANCHES*MAX_DEPTH];
  logic [`FIC_BRANCHES-1:0][DEPTH_W-1:0] depth_q;
  logic [`FIC_BRANCHES-1:0][DEPTH_W-1:0] ptr_q;
  logic [5:0]         br_q;
  logic [5:0]         ti_b;
  logic [DEPTH_W-1:0] ti_d;
  logic [DEPTH_W-1:0] ti_pn;
  int                 ti_idx;
  logic [3:0]         cu_q;
  logic [3:0]         cu_now;
  assign take   = fq_vld && (!out_valid || out_ready);
  assign ti_b   = fq_unit.sow ? 6'h00 : br_q;
  assign ti_d   = (ti_b == 6'h00) ? '0 : depth_q[ti_b];
  assign ti_pn  = ptr_q[ti_b] + 1'b1;
  assign ti_idx = int'(ti_b) * MAX_DEPTH + int'(ptr_q[ti_b]);
  assign cu_now = fq_unit.sow ? 4'h0 : cu_q;

  always_ff @(posedge clk_sys)
  begin
    if (take && !fq_unit.sig && ti_d != '0)
    begin
      tmem[ti_idx] <= fq_unit.data;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      br_q    <= 6'h00;
      depth_q <= '0;
      ptr_q   <= '0;
    end
    else if (take && !fq_unit.sig)
    begin
      br_q <= (ti_b == 6'(`FIC_BRANCHES - 1)) ? 6'h00 : ti_b + 6'h01;
      for (int j = 0; j < `FIC_BRANCHES; j++)
      begin
        if (fq_unit.sow)
        begin
          depth_q[j] <= (j == 0) ? '0 : fic_clamp(tap_depth[j]);
          if (ptr_q[j] >= fic_clamp(tap_depth[j]))
          begin
            ptr_q[j] <= '0;
          end
        end
        else if (j == int'(ti_b) && ti_d != '0)
        begin
          ptr_q[j] <= (ti_pn >= ti_d) ? '0 : ti_pn;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out_unit  <= '0;
      out_valid <= 1'b0;
      cu_q      <= 4'h0;
    end
    else if (take)
    begin
      out_valid        <= 1'b1;
      out_unit.sow     <= fq_unit.sow;
      out_unit.sig     <= fq_unit.sig;
      out_unit.cu_last <= cu_now == 4'(`FIC_CU_UNITS - 1);
      out_unit.data    <= (fq_unit.sig || ti_d == '0) ? fq_unit.data : tmem[ti_idx];
      cu_q             <= cu_now + 4'h1;
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end

  AST_TB_N6: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tb_start && !tb_busy && tb_len == `FIC_TB_SIG |=> tb_n_q == 4'h6)
    else $error("n not 6 for signalling block");
  AST_TB_N9: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tb_start && !tb_busy && tb_len == `FIC_TB_PAY |=> tb_n_q == 4'h9)
    else $error("n not 9 for payload block");
  AST_TB_CLR: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tb_start && !tb_busy && tb_len != 14'h0000 |=> tb_cnt_q == 14'h0000 && tb_emit_q == 14'h0000)
    else $error("address counter not cleared");
  AST_TB_LT: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tb_addr_valid |-> tb_addr < tb_len_q)
    else $error("address beyond block length");
  AST_BUSY_BP: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_step && rd_last |-> !in_ready ##1 in_ready)
    else $error("back-pressure not released after word");
  AST_H_RANGE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_q == fic_pkg::FIC_ST_READ |-> h_q < clen_q)
    else $error("permuted index out of range");
  AST_PUNCT: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_step && !sig_q && g_q >= 7'h7E && !rd_last |=> $stable(pk_cnt_q))
    else $error("punctured bit was packed");
  AST_BR_WRAP: assert property (@(posedge clk_sys) disable iff (!arst_n)
    take && !fq_unit.sig && ti_b == 6'h2F |=> br_q == 6'h00)
    else $error("branch selector did not wrap after 48");
  AST_SOW_BR: assert property (@(posedge clk_sys) disable iff (!arst_n)
    take && !fq_unit.sig && fq_unit.sow |=> br_q == 6'h01 && out_unit.sow)
    else $error("cycle not aligned to word start");
  AST_BR0: assert property (@(posedge clk_sys) disable iff (!arst_n)
    take && ti_b == 6'h00 |=> out_unit.data == $past(fq_unit.data))
    else $error("branch zero delayed its unit");
endmodule

// *** pkg/fic_defs.svh ***
// Constants of the interleaving chain: sizes, block lengths, reset values.
// Assumes inclusion by bare name from the package only.
`ifndef FIC_DEFS_SVH
`define FIC_DEFS_SVH
`define FIC_UNIT_BITS  126
`define FIC_GROUP_BITS 128
`define FIC_BRANCHES   48
`define FIC_CU_UNITS   16
`define FIC_TB_SIG     14'h047A
`define FIC_TB_PAY     14'h2FFA
`define FIC_SIG_LEN    17'h01680
`define FIC_SIG_MULT   8'h49
`define FIC_ADDR_RST   14'h0000
`endif

// *** pkg/fic_pkg.sv ***
// Types of the interleaving chain.
// Assumes fic_defs.svh on the include path.
`include "fic_defs.svh"
package fic_pkg;
  typedef struct packed {
    logic                      sow;
    logic                      sig;
    logic                      cu_last;
    logic [`FIC_UNIT_BITS-1:0] data;
  } fic_unit_t;
  typedef enum logic [1:0] {
    FIC_ST_IDLE = 2'b00,
    FIC_ST_FILL = 2'b01,
    FIC_ST_READ = 2'b10
  } fic_state_t;
endpackage

// *** dv/fic_partner.sv ***
// Frame assembler stand-in: takes units, stalls at random and on demand.
// Assumes the chain's unit handshake on the same clock.
`timescale 1ns/100ps
module fic_partner (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic hold,
  output logic      out_ready
);
  logic [15:0] lfsr_q;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lfsr_q    <= 16'hACE1;
      out_ready <= 1'b0;
    end
    else
    begin
      lfsr_q    <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      // Roughly one stall in eight, plus long stalls on demand
      out_ready <= !hold && (lfsr_q[2:0] != 3'h0);
    end
  end
endmodule

// *** dv/tb_fic_chain.sv ***
// Bench of the interleaving chain: turbo addresses, signalling and payload words.
// Assumes fic_chain with small delay memories and fic_partner as unit sink.
`timescale 1ns/100ps
module tb_fic_chain;
  localparam int DW = 4;
  localparam int T6[32] = '{3, 27, 15, 13, 29, 5, 1, 31, 3, 9, 15, 31, 17, 5, 39, 1, 19, 27,
                            15, 13, 45, 5, 33, 15, 13, 9, 15, 31, 17, 5, 15, 33};
  localparam int T9[32] = '{13, 335, 87, 15, 15, 1, 333, 11, 13, 1, 121, 155, 1, 175, 421, 5,
                            509, 215, 47, 425, 295, 229, 427, 83, 409, 387, 193, 57, 501, 313,
                            489, 391};
  localparam int MUL[8] = '{247, 245, 221, 197, 185, 167, 157, 125};
  logic                clk_sys   = 1'b0;
  logic                arst_n    = 1'b0;
  logic                tb_start  = 1'b0;
  logic [13:0]         tb_len    = 14'h0000;
  logic                in_bit    = 1'b0;
  logic                in_sow    = 1'b0;
  logic                in_valid  = 1'b0;
  logic [2:0]          rate_sel  = 3'h0;
  logic                sig_word  = 1'b0;
  logic                hold      = 1'b0;
  logic [47:0][DW-1:0] tap_depth = '0;
  logic [13:0]         tb_addr;
  logic                tb_addr_valid;
  logic                tb_done;
  logic                tb_busy;
  logic                in_ready;
  logic                out_valid;
  logic                out_ready;
  fic_pkg::fic_unit_t  out_unit;
  int                  failures  = 0;
  int                  n_tests   = 0;
  logic [31:0]         rs        = 32'h00000025;
  logic [13:0]         aq[$];
  fic_pkg::fic_unit_t  uq[$];
  bit                  dq[$];
  logic [125:0]        hist[48][$];
  int                  dep[48];
  bit                  a[];

  always #25 clk_sys = ~clk_sys;

  fic_chain #(.MAX_DEPTH(8), .DEPTH_W(DW)) fic_chain_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .tb_start(tb_start), .tb_len(tb_len),
    .tb_addr(tb_addr), .tb_addr_valid(tb_addr_valid), .tb_done(tb_done),
    .tb_busy(tb_busy), .in_bit(in_bit), .in_sow(in_sow), .in_valid(in_valid),
    .in_ready(in_ready), .rate_sel(rate_sel), .sig_word(sig_word), .tap_depth(tap_depth),
    .out_unit(out_unit), .out_valid(out_valid), .out_ready(out_ready)
  );

  fic_partner fic_partner_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .hold(hold), .out_ready(out_ready)
  );

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Expected address list first, then start; a second start while busy must be ignored
  task automatic turbo(input int len);
    int n;
    int c;
    int k;
    int p;
    int rev;
    n = 0;
    while (len > (1 << (n + 5)))
      n++;
    for (c = 0; c < (1 << (n + 5)); c++)
    begin
      p = ((c >> 5) + 1) % (1 << n);
      p = (p * (n == 9 ? T9[c % 32] : T6[c % 32])) % (1 << n);
      rev = 0;
      for (k = 0; k < 5; k++)
        rev = rev | (((c >> k) & 1) << (4 - k));
      if (((rev << n) | p) < len)
        aq.push_back(14'((rev << n) | p));
    end
    @(posedge clk_sys);
    #2;
    tb_len = 14'(len);
    tb_start = 1'b1;
    @(posedge clk_sys);
    #2;
    tb_start = 1'b0;
    @(posedge clk_sys);
    #2;
    chk(tb_busy, 1'b1);
    tb_len = 14'h0005;
    tb_start = 1'b1;
    @(posedge clk_sys);
    #2;
    tb_start = 1'b0;
    for (c = 0; c < 20000 && aq.size() > 0; c++)
      @(posedge clk_sys);
    #2;
    chk(aq.size(), 0);
  endtask

  task automatic put(input bit s, input bit d);
    in_valid = 1'b1;
    in_sow = s;
    in_bit = d;
    while (in_ready !== 1'b1)
    begin
      @(posedge clk_sys);
      #2;
    end
    @(posedge clk_sys);
    #2;
  endtask

  // One coded word; abort first sends short restarted words at rates 0 to 5
  task automatic word(input bit sg, input int r, input bit abort);
    int nb;
    int nu;
    int k;
    int j;
    int w;
    int b;
    fic_pkg::fic_unit_t u;
    nb = sg ? 5760 : 61440 - 6144 * r;
    nu = sg ? 46 : nb / 128;
    a = new[nb];
    foreach (a[i])
      a[i] = xs() % 2 == 1;
    for (k = 0; k < nu; k++)
    begin
      u = '0;
      for (j = 0; j < 126; j++)
      begin
        w = sg ? 126 * k + j : 128 * k + j;
        if (w < nb)
          u.data[j] = a[((sg ? 73 : MUL[r]) * w) % nb];
      end
      u.sow = k == 0;
      u.sig = sg;
      u.cu_last = k % 16 == 15;
      b = k % 48;
      dq.push_back(1'b0);
      if (!sg)
      begin
        hist[b].push_back(u.data);
        if (hist[b].size() > dep[b])
          u.data = hist[b][hist[b].size() - 1 - dep[b]];
        else
          dq[$] = 1'b1;
      end
      uq.push_back(u);
    end
    for (k = 0; abort && k < 6; k++)
    begin
      rate_sel = 3'(k);
      for (j = 0; j < 40; j++)
        put(j == 0, a[j]);
    end
    rate_sel = 3'(r);
    sig_word = sg;
    for (k = 0; k < nb; k++)
      put(k == 0, a[k]);
    in_valid = 1'b0;
    @(posedge clk_sys);
    #2;
  endtask

  always @(posedge clk_sys)
  begin
    if (tb_addr_valid === 1'b1)
    begin
      chk(aq.size() != 0, 1'b1);
      if (aq.size() != 0)
        chk(tb_addr, aq.pop_front());
      chk(tb_done, aq.size() == 0);
    end
    else if (tb_done === 1'b1)
      chk(tb_done, 1'b0);
    if (out_valid === 1'b1 && out_ready === 1'b1)
    begin
      chk(uq.size() != 0, 1'b1);
      if (uq.size() != 0)
      begin
        chk({out_unit.sow, out_unit.sig, out_unit.cu_last},
            {uq[0].sow, uq[0].sig, uq[0].cu_last});
        if (!dq[0])
          chk(out_unit.data, uq[0].data);
        uq.delete(0);
        dq.delete(0);
      end
    end
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    complete_run();
  end

  initial
  begin
    for (int i = 0; i < 48; i++)
    begin
      dep[i] = i == 0 ? 0 : int'(xs() % 4);
      tap_depth[i] = i == 0 ? 4'hF : DW'(dep[i]);
    end
    repeat (2) @(posedge clk_sys);
    #2;
    chk({in_ready, out_valid, tb_addr_valid}, 3'h4);
    arst_n = 1'b1;
    fork
      begin
        turbo(1146);
        turbo(12282);
      end
      begin
        word(1'b0, 7, 1'b1);
        word(1'b1, 0, 1'b0);
        word(1'b0, 7, 1'b0);
        hold = 1'b1;
        // Long enough to fill the unit FIFO and halt read-out
        repeat (3000) @(posedge clk_sys);
        #2;
        chk({out_valid, in_ready}, 2'h2);
        hold = 1'b0;
      end
    join
    for (int i = 0; i < 60000 && uq.size() > 0; i++)
      @(posedge clk_sys);
    chk(uq.size(), 0);
    complete_run();
  end
endmodule
